/* File: verilog/asu_serial_status.sv */
// Serial port control, status, GPIO pins, transmitter and combined interrupt
//
// The strobed register port was decided locally.
`include "asu_defines.svh"
// Functional notes
// - Idle transmit line is high, or low when idle_break_level is set.
// - Four direction bits: 0 input, 1 output; all reset to input.
// - Sixteen-bit status word at FFF6h; top bit always reads zero.
// - Pin level bits show pins; writes stick only on output pins.
// - Pin change flags clear on writing 1; reset leaves flags and levels.
// - Upper or lower A with autobaud enabled sets bit 14; write 1 clears.
// - Autobaud flag with autobaud enable holds the interrupt regardless of masks.
// - Break on receive line sets bit 13 and interrupts; write 1 clears.
// - Bit 12 reads 1 only when holding and shift registers are empty.
// - Bit 11 sets on move to shifter, clears on new load, resets 1.
// - Holding register emptying raises the interrupt under the transmit mask.
// - Missing stop bit sets bit 10 and interrupts; write 1 clears.
// - Overwriting an unread character sets bit 9 and interrupts; write 1 clears.
// - Complete character sets bit 8; reading the character clears it.
// - Pin changes are flagged only on input pins with the port running.
// - Receive, transmit and pin events reach the interrupt through their masks.
// - Stop bit selector gives one or two stop bits both ways.
module asu_serial_status (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        rx_i,
	input  wire logic [3:0]  pin_i,
	output logic [15:0]      rdata_o,
	output logic             tx_o,
	output logic [3:0]       pin_o,
	output logic [3:0]       pin_oe_o,
	output logic             port_irq_o
);
	import asu_pkg::*;

	asu_state_t   r;
	asu_state_t   n;
	asu_pin_mem_t m;
	asu_pin_mem_t mn;
	logic         rx_done;
	logic         rx_ferr;
	logic         rx_brk;
	logic [7:0]   rx_data;
	logic         port_run_n_reset;
	logic         tx_buf_empty;
	logic         tx_all_empty;
	logic         tx_ev;
	logic         rx_ev;
	logic         pin_ev;
	logic         rd_char;
	logic [3:0]   lvl;
	logic [15:0]  stat_w;

	function automatic logic asu_hit(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction : asu_hit

	asu_rx u_rx (
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.tick_i     (r.tick),
		.en_i       (port_run_n_reset),
		.rx_i       (r.rx_s2),
		.two_stop_i (r.ctl[`ASU_B_STB]),
		.done_o     (rx_done),
		.data_o     (rx_data),
		.ferr_o     (rx_ferr),
		.brk_o      (rx_brk)
	);

	always_comb begin
		n = r;
		mn = m;
		tx_ev = 1'b0;
		pin_ev = 1'b0;
		port_run_n_reset = r.ctl[`ASU_B_PORT_RUN_N_RESET];
		rd_char = rd_i && asu_hit(addr_i, `ASU_A_DATA);
		// holding empty ignores the shifter; all empty needs both stages idle
		tx_buf_empty = !r.thr_full;
		tx_all_empty = tx_buf_empty && (r.tx_st == ASU_TX_IDLE);
		// output pins read back their latch
		for (int i = 0; i < 4; i++) begin
			lvl[i] = r.ctl[i] ? m.lat[i] : r.pin_s2[i];
		end
		stat_w = {1'b0, r.adc, r.brk, tx_all_empty, tx_buf_empty, r.ferr, r.ovr, r.rdy, m.chg, lvl};

		n.rx_s1 = rx_i;
		n.rx_s2 = r.rx_s1;
		n.pin_s1 = pin_i;
		n.pin_s2 = r.pin_s1;
		n.pin_prev = r.pin_s2;
		n.tick = (r.div == 7'(`ASU_TICK_CYC - 1));
		n.div = n.tick ? 7'h00 : 7'(r.div + 7'h01);

		// Transmitter runs first so a load in the same cycle wins over the move
		if (r.tick) begin
			n.tx_tcnt = 4'(r.tx_tcnt + 4'h1);
			unique case (r.tx_st)
				ASU_TX_IDLE: begin
					n.tx_tcnt = 4'h0;
					// move to shifter empties holding register
					if (r.thr_full) begin
						n.tx_sh = r.thr;
						n.thr_full = 1'b0;
						n.tx_st = ASU_TX_START;
						tx_ev = 1'b1;
					end
				end
				ASU_TX_START: begin
					if (r.tx_tcnt == `ASU_LAST_TICK) begin
						n.tx_bcnt = 3'h0;
						n.tx_st = ASU_TX_DATA;
					end
				end
				ASU_TX_DATA: begin
					if (r.tx_tcnt == `ASU_LAST_TICK) begin
						n.tx_sh = {1'b0, r.tx_sh[7:1]};
						n.tx_bcnt = 3'(r.tx_bcnt + 3'h1);
						if (r.tx_bcnt == `ASU_LAST_BIT) begin
							n.tx_stop2 = 1'b0;
							n.tx_st = ASU_TX_STOP;
						end
					end
				end
				ASU_TX_STOP: begin
					if (r.tx_tcnt == `ASU_LAST_TICK) begin
						if (r.ctl[`ASU_B_STB] && !r.tx_stop2) begin
							n.tx_stop2 = 1'b1;
						end else begin
							n.tx_st = ASU_TX_IDLE;
						end
					end
				end
			endcase
		end

		if (wr_i) begin
			if (asu_hit(addr_i, `ASU_A_CTRL)) begin
				n.ctl = wdata_i & `ASU_CTRL_WMASK;
			end
			if (asu_hit(addr_i, `ASU_A_STAT)) begin
				if (wdata_i[`ASU_S_ADC]) begin
					n.adc = 1'b0;
				end
				if (wdata_i[`ASU_S_BRK]) begin
					n.brk = 1'b0;
				end
				if (wdata_i[`ASU_S_FE]) begin
					n.ferr = 1'b0;
				end
				if (wdata_i[`ASU_S_OVR]) begin
					n.ovr = 1'b0;
				end
				mn.chg = m.chg & ~wdata_i[7:4];
				// only output pins take the write
				for (int i = 0; i < 4; i++) begin
					if (r.ctl[i]) begin
						mn.lat[i] = wdata_i[i];
					end
				end
			end
			// a new load clears the empty flag
			if (asu_hit(addr_i, `ASU_A_DATA) && port_run_n_reset) begin
				n.thr = wdata_i[7:0];
				n.thr_full = 1'b1;
			end
			if (asu_hit(addr_i, `ASU_A_EMSK)) begin
				n.emask = wdata_i[2:0];
			end
		end

		n.rd_data = 16'h0000;
		if (rd_i) begin
			if (rd_char) begin
				n.rd_data = {8'h00, r.rbuf};
				n.rdy = 1'b0;
			end
			if (asu_hit(addr_i, `ASU_A_CTRL)) begin
				n.rd_data = r.ctl;
			end
			if (asu_hit(addr_i, `ASU_A_STAT)) begin
				n.rd_data = stat_w;
			end
			if (asu_hit(addr_i, `ASU_A_EVT)) begin
				n.rd_data = {13'h0000, r.evt};
				n.evt = 3'h0;
			end
			if (asu_hit(addr_i, `ASU_A_EMSK)) begin
				n.rd_data = {13'h0000, r.emask};
			end
		end

		// Flag sets follow the clears so a same-cycle event is never lost
		rx_ev = rx_done | rx_brk;
		if (rx_done) begin
			n.rbuf = rx_data;
			if (r.rdy && !rd_char) begin
				n.ovr = 1'b1;
			end
			n.rdy = 1'b1;
			if (rx_ferr) begin
				n.ferr = 1'b1;
			end
			if (r.ctl[`ASU_B_CAD] && (rx_data == `ASU_CHAR_UA || rx_data == `ASU_CHAR_LA)) begin
				n.adc = 1'b1;
			end
		end
		if (rx_brk) begin
			n.brk = 1'b1;
		end
		for (int i = 0; i < 4; i++) begin
			if (port_run_n_reset && !r.ctl[i] && (r.pin_s2[i] != r.pin_prev[i])) begin
				mn.chg[i] = 1'b1;
				pin_ev = 1'b1;
			end
		end

		// Port reset holds the serial side idle; pin bits are left alone
		if (!port_run_n_reset) begin
			n.adc = 1'b0;
			n.brk = 1'b0;
			n.ferr = 1'b0;
			n.ovr = 1'b0;
			n.rdy = 1'b0;
			n.thr_full = 1'b0;
			n.tx_st = ASU_TX_IDLE;
		end

		// each class gated by its own mask
		n.evt[`ASU_E_RX] = n.evt[`ASU_E_RX] | (rx_ev & r.ctl[`ASU_B_RIM]);
		n.evt[`ASU_E_TX] = n.evt[`ASU_E_TX] | (tx_ev & r.ctl[`ASU_B_TIM]);
		n.evt[`ASU_E_PIN] = n.evt[`ASU_E_PIN] | (pin_ev & r.ctl[`ASU_B_DIM]);
		n.irq = (n.adc & n.ctl[`ASU_B_CAD]) | (|(n.evt & n.emask));

		unique case (n.tx_st)
			ASU_TX_IDLE:  n.tx_o = ~n.ctl[`ASU_B_BRK];
			ASU_TX_START: n.tx_o = 1'b0;
			ASU_TX_DATA:  n.tx_o = n.tx_sh[0];
			ASU_TX_STOP:  n.tx_o = 1'b1;
		endcase
		n.pin_oe = n.ctl[3:0];
		n.pin_o = mn.lat & n.ctl[3:0];
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= '0;
			r.ctl <= `ASU_CTRL_RST;
			r.rx_s1 <= 1'b1;
			r.rx_s2 <= 1'b1;
			r.tx_o <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// no reset: pin latches and change flags survive device reset
	always_ff @(posedge clk_i) begin
		m <= mn;
	end

	assign rdata_o    = r.rd_data;
	assign tx_o       = r.tx_o;
	assign pin_o      = r.pin_o;
	assign pin_oe_o   = r.pin_oe;
	assign port_irq_o = r.irq;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	chk_idle_tx_level: assert property (
		(wr_i && asu_hit(addr_i, `ASU_A_CTRL) && r.tx_st == ASU_TX_IDLE && !r.thr_full)
		|=> (tx_o == !$past(wdata_i[`ASU_B_BRK])))
		else $error("idle transmit level wrong");

	chk_pin_dir_out: assert property (
		(wr_i && asu_hit(addr_i, `ASU_A_CTRL)) |=> (pin_oe_o == $past(wdata_i[3:0])))
		else $error("pin enable not following direction");

	chk_stat_top_zero: assert property (
		(rd_i && asu_hit(addr_i, `ASU_A_STAT)) |=> (rdata_o[15] == 1'b0))
		else $error("status top bit not zero");

	chk_input_pin_write: assert property (
		(wr_i && asu_hit(addr_i, `ASU_A_STAT) && !r.ctl[0])
		|=> $stable(m.lat[0]))
		else $error("input pin latch written");

	chk_adc_set: assert property (
		(rx_done && r.ctl[`ASU_B_PORT_RUN_N_RESET] && r.ctl[`ASU_B_CAD] && rx_data == `ASU_CHAR_UA)
		|=> r.adc)
		else $error("autobaud flag not set");

	chk_adc_irq_hold: assert property (
		(r.adc && r.ctl[`ASU_B_CAD]) [*2] |-> port_irq_o)
		else $error("autobaud interrupt not held");

	chk_break_flag: assert property (
		(rx_brk && r.ctl[`ASU_B_PORT_RUN_N_RESET]) |=> r.brk)
		else $error("break flag not set");

	chk_tx_empty_rel: assert property (
		(rd_i && asu_hit(addr_i, `ASU_A_STAT) && r.thr_full) |=> !rdata_o[`ASU_S_TX_ALL_EMPTY])
		else $error("transmit empty with full holding register");

	sequence s_tx_move;
		r.tick && r.ctl[`ASU_B_PORT_RUN_N_RESET] && r.tx_st == ASU_TX_IDLE && r.thr_full
			&& !(wr_i && asu_hit(addr_i, `ASU_A_DATA));
	endsequence
	sequence s_tx_started;
		!r.thr_full && r.tx_st == ASU_TX_START ##1 !tx_o;
	endsequence
	chk_tx_move_start: assert property (
		s_tx_move |=> s_tx_started)
		else $error("holding register move failed");

	chk_tx_event_irq: assert property (
		(s_tx_move ##0 r.ctl[`ASU_B_TIM] && r.emask[`ASU_E_TX] && !rd_i) |=> ##1 port_irq_o)
		else $error("transmit interrupt missing");

	chk_frame_err: assert property (
		(rx_done && rx_ferr && r.ctl[`ASU_B_PORT_RUN_N_RESET]) |=> r.ferr)
		else $error("framing flag not set");

	chk_overrun: assert property (
		(rx_done && r.rdy && !rd_char && r.ctl[`ASU_B_PORT_RUN_N_RESET]) |=> r.ovr)
		else $error("overrun flag not set");

	chk_rx_mask_off: assert property (
		(rx_done && !r.ctl[`ASU_B_RIM] && !rd_i) |=> $stable(r.evt[`ASU_E_RX]))
		else $error("masked receive event recorded");

	chk_pin_change: assert property (
		(r.ctl[`ASU_B_PORT_RUN_N_RESET] && !r.ctl[1] && r.pin_s2[1] != r.pin_prev[1]) |=> m.chg[1])
		else $error("pin change not flagged");
endmodule : asu_serial_status

/* File: verilog/asu_defines.svh */
// Register map, field positions, reset values and timing counts of the serial status block
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH
`define ASU_A_DATA     16'hFFF4
`define ASU_A_CTRL     16'hFFF5
`define ASU_A_STAT     16'hFFF6
`define ASU_A_EVT      16'hFFF7
`define ASU_A_EMSK     16'hFFF8
`define ASU_CTRL_WMASK 16'hE3FF
`define ASU_CTRL_RST   16'h0000
`define ASU_B_PORT_RUN_N_RESET     13
`define ASU_B_DIM      9
`define ASU_B_TIM      8
`define ASU_B_RIM      7
`define ASU_B_STB      6
`define ASU_B_CAD      5
`define ASU_B_BRK      4
`define ASU_S_ADC      14
`define ASU_S_BRK      13
`define ASU_S_TX_ALL_EMPTY     12
`define ASU_S_TX_BUF_EMPTY     11
`define ASU_S_FE       10
`define ASU_S_OVR      9
`define ASU_S_RDY      8
`define ASU_E_RX       0
`define ASU_E_TX       1
`define ASU_E_PIN      2
`define ASU_CHAR_UA    8'h41
`define ASU_CHAR_LA    8'h61
`define ASU_CLK_HZ     10000000
`define ASU_BAUD       9600
`define ASU_OVS        16
`define ASU_TICK_CYC   ((`ASU_CLK_HZ) / ((`ASU_BAUD) * (`ASU_OVS)))
`define ASU_MID_TICK   4'h7
`define ASU_LAST_TICK  4'hF
`define ASU_LAST_BIT   3'h7
`endif

/* File: verilog/asu_pkg.sv */
// Types shared by the serial status block and its receiver
package asu_pkg;
	typedef enum logic [1:0] {
		ASU_TX_IDLE  = 2'b00,
		ASU_TX_START = 2'b01,
		ASU_TX_DATA  = 2'b10,
		ASU_TX_STOP  = 2'b11
	} asu_tx_st_t;

	typedef enum logic [2:0] {
		ASU_RX_IDLE  = 3'b000,
		ASU_RX_START = 3'b001,
		ASU_RX_DATA  = 3'b010,
		ASU_RX_STOP  = 3'b011,
		ASU_RX_WAIT  = 3'b100
	} asu_rx_st_t;

	typedef struct packed {
		asu_rx_st_t st;
		logic [3:0] tcnt;
		logic [2:0] bcnt;
		logic [7:0] sh;
		logic       stop2;
		logic       bad;
		logic       done;
		logic [7:0] data;
		logic       ferr;
		logic       brk;
	} asu_rx_state_t;

	typedef struct packed {
		logic [15:0] ctl;
		logic        adc;
		logic        brk;
		logic        ferr;
		logic        ovr;
		logic        rdy;
		logic        thr_full;
		logic [7:0]  thr;
		asu_tx_st_t  tx_st;
		logic [3:0]  tx_tcnt;
		logic [2:0]  tx_bcnt;
		logic [7:0]  tx_sh;
		logic        tx_stop2;
		logic [7:0]  rbuf;
		logic [15:0] rd_data;
		logic [2:0]  evt;
		logic [2:0]  emask;
		logic        irq;
		logic        tx_o;
		logic [3:0]  pin_o;
		logic [3:0]  pin_oe;
		logic        rx_s1;
		logic        rx_s2;
		logic [3:0]  pin_s1;
		logic [3:0]  pin_s2;
		logic [3:0]  pin_prev;
		logic [6:0]  div;
		logic        tick;
	} asu_state_t;

	typedef struct packed {
		logic [3:0] chg;
		logic [3:0] lat;
	} asu_pin_mem_t;
endpackage : asu_pkg

/* File: verilog/asu_rx.sv */
// Serial receiver: start, eight data bits, one or two stop bits, framing and break detection
`include "asu_defines.svh"
module asu_rx (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       tick_i,
	input  wire logic       en_i,
	input  wire logic       rx_i,
	input  wire logic       two_stop_i,
	output logic            done_o,
	output logic [7:0]      data_o,
	output logic            ferr_o,
	output logic            brk_o
);
	import asu_pkg::*;

	asu_rx_state_t r;
	asu_rx_state_t n;
	logic          bad_n;

	always_comb begin
		n = r;
		n.done = 1'b0;
		n.ferr = 1'b0;
		n.brk = 1'b0;
		bad_n = r.bad | ~rx_i;
		if (!en_i) begin
			n.st = ASU_RX_IDLE;
		end else if (tick_i) begin
			n.tcnt = 4'(r.tcnt + 4'h1);
			unique case (r.st)
				ASU_RX_IDLE: begin
					n.tcnt = 4'h0;
					if (!rx_i) begin
						n.st = ASU_RX_START;
					end
				end
				ASU_RX_START: begin
					// Mid start bit; a short glitch returns to idle
					if (r.tcnt == `ASU_MID_TICK) begin
						n.tcnt = 4'h0;
						n.bcnt = 3'h0;
						n.st = rx_i ? ASU_RX_IDLE : ASU_RX_DATA;
					end
				end
				ASU_RX_DATA: begin
					if (r.tcnt == `ASU_LAST_TICK) begin
						n.sh = {rx_i, r.sh[7:1]};
						n.bcnt = 3'(r.bcnt + 3'h1);
						if (r.bcnt == `ASU_LAST_BIT) begin
							n.st = ASU_RX_STOP;
							n.stop2 = 1'b0;
							n.bad = 1'b0;
						end
					end
				end
				ASU_RX_STOP: begin
					if (r.tcnt == `ASU_LAST_TICK) begin
						if (two_stop_i && !r.stop2) begin
							n.stop2 = 1'b1;
							n.bad = bad_n;
						end else if (bad_n && r.sh == 8'h00) begin
							n.brk = 1'b1;
							n.st = ASU_RX_WAIT;
						end else begin
							n.done = 1'b1;
							n.data = r.sh;
							n.ferr = bad_n;
							n.st = bad_n ? ASU_RX_WAIT : ASU_RX_IDLE;
						end
					end
				end
				ASU_RX_WAIT: begin
					// Line must return high before a new start is trusted
					if (rx_i) begin
						n.st = ASU_RX_IDLE;
					end
				end
				default: begin
					n.st = ASU_RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign done_o = r.done;
	assign data_o = r.data;
	assign ferr_o = r.ferr;
	assign brk_o  = r.brk;
endmodule : asu_rx

/* File: testbench/asu_remote_serial.sv */
// Remote serial device model: sends frames on demand, receives what the port transmits
`include "asu_defines.svh"
module asu_remote_serial (
	input  wire logic clk_i,
	input  wire logic line_i,
	input  wire logic listen_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT_CYC = `ASU_TICK_CYC * 16;
	logic [7:0] got_byte;
	logic [7:0] sh;
	int         got_cnt;
	initial begin
		line_o   = 1'h1;
		got_byte = 8'h00;
		sh       = 8'h00;
		got_cnt  = 0;
	end
	task automatic hold_bit(input logic v);
		line_o <= v;
		repeat (BIT_CYC) @(posedge clk_i);
	endtask : hold_bit
	// stop bit level
	// Start low, LSB first; stop_ok low breaks the frame on purpose
	task automatic send_char(input logic [7:0] c, input logic stop_ok);
		hold_bit(1'h0);
		for (int i = 0; i < 8; i++) begin
			hold_bit(c[i]);
		end
		hold_bit(stop_ok);
		hold_bit(1'h1);
	endtask : send_char
	// one stop bit
	// Checks only the first stop bit, so two-stop frames are accepted too
	always begin
		@(negedge line_i iff listen_i);
		repeat (BIT_CYC / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_i);
			sh[i] = line_i;
		end
		repeat (BIT_CYC) @(posedge clk_i);
		if (line_i === 1'h1) begin
			got_byte = sh;
			got_cnt++;
		end
	end
endmodule : asu_remote_serial

/* File: testbench/asu_serial_status_tb_top.sv */
// Self-checking bench of the serial status block
module asu_serial_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] waddr;
		logic [15:0] wdata;
		logic [15:0] raddr;
		logic [15:0] exp;
		logic [15:0] mask;
	} asu_row_t;
	logic        clk = 1'h0;
	logic        resetn = 1'h0;
	logic        wr = 1'h0;
	logic        rd = 1'h0;
	logic        listen = 1'h0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [3:0]  ext_pins = 4'h0;
	logic [15:0] rv;
	logic [15:0] rdata;
	logic        tx;
	logic        rx_line;
	logic        irq;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	wire  [3:0]  pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_pins);
	int          failures = 0;
	int          tests_run = 0;
	// Control mask, control reset, unmapped place, reserved status bit
	asu_row_t rows [4] = '{
		'{16'hFFF5, 16'hFFFF, 16'hFFF5, 16'hE3FF, 16'hFFFF},
		'{16'hFFF5, 16'h0000, 16'hFFF5, 16'h0000, 16'hFFFF},
		'{16'hFFF0, 16'hFFFF, 16'hFFF0, 16'h0000, 16'hFFFF},
		'{16'hFFF6, 16'h8000, 16'hFFF6, 16'h1800, 16'hF800}
	};
	asu_serial_status i_asu_serial_status (
		.clk_i      (clk),
		.resetn_i   (resetn),
		.addr_i     (addr),
		.wdata_i    (wdata),
		.wr_i       (wr),
		.rd_i       (rd),
		.rx_i       (rx_line),
		.pin_i      (pin_lvl),
		.rdata_o    (rdata),
		.tx_o       (tx),
		.pin_o      (pin_out),
		.pin_oe_o   (pin_oe),
		.port_irq_o (irq)
	);
	asu_remote_serial i_asu_remote_serial (
		.clk_i    (clk),
		.line_i   (tx),
		.listen_i (listen),
		.line_o   (rx_line)
	);
	always #50 clk = ~clk;
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc
	task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : bus_wr
	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		d = rdata;
	endtask : bus_rd
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
		tests_run++;
		if ((got & mask) !== (exp & mask)) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got & mask, exp & mask);
		end
	endtask : chk
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic [15:0] mask);
		bus_rd(a, rv);
		chk(rv, exp, mask);
	endtask : rd_chk
	// Step past the edge so a level launched on it has settled
	task automatic bit_chk(input logic got, input logic exp);
		#1;
		chk({15'h0000, got}, {15'h0000, exp}, 16'h0001);
	endtask : bit_chk
	initial begin
		#9500000;
		failures++;
		print_verdict();
	end
	initial begin
		wait_cyc(6);
		resetn <= 1'h1;
		rd_chk(16'hFFF6, 16'h1800, 16'hFF00);
		bit_chk(tx, 1'h1);
		chk({12'h000, pin_oe}, 16'h0000, 16'h000F);
		for (int i = 0; i < 4; i++) begin
			bus_wr(rows[i].waddr, rows[i].wdata);
			rd_chk(rows[i].raddr, rows[i].exp, rows[i].mask);
		end
		bus_wr(16'hFFF5, 16'h0010);
		wait_cyc(2);
		bit_chk(tx, 1'h0);
		bus_wr(16'hFFF5, 16'h000F);
		bus_wr(16'hFFF6, 16'h000A);
		wait_cyc(4);
		bit_chk(tx, 1'h1);
		chk({12'h000, pin_oe}, 16'h000F, 16'h000F);
		chk({12'h000, pin_out}, 16'h000A, 16'h000F);
		bus_wr(16'hFFF5, 16'h0003);
		bus_wr(16'hFFF6, 16'h00FF);
		wait_cyc(4);
		rd_chk(16'hFFF6, 16'h0003, 16'h000F);
		ext_pins <= 4'h4;
		wait_cyc(6);
		rd_chk(16'hFFF6, 16'h0000, 16'h00F0);
		bus_wr(16'hFFF8, 16'h0007);
		bus_wr(16'hFFF5, 16'h2203);
		wait_cyc(4);
		bus_wr(16'hFFF6, 16'h00F0);
		wait_cyc(6);
		ext_pins <= 4'hC;
		wait_cyc(6);
		// Output pins 1..0 were written low by the flag clear above
		rd_chk(16'hFFF6, 16'h008C, 16'h00FF);
		bit_chk(irq, 1'h1);
		bus_wr(16'hFFF6, 16'h0080);
		bus_rd(16'hFFF7, rv);
		wait_cyc(3);
		rd_chk(16'hFFF6, 16'h0000, 16'h00F0);
		bit_chk(irq, 1'h0);
		listen <= 1'h1;
		bus_wr(16'hFFF5, 16'h2100);
		bus_wr(16'hFFF4, 16'h005A);
		rd_chk(16'hFFF6, 16'h0000, 16'h1000);
		wait_cyc(200);
		rd_chk(16'hFFF6, 16'h0800, 16'h1800);
		bit_chk(irq, 1'h1);
		wait_cyc(11000);
		rd_chk(16'hFFF6, 16'h1800, 16'h1800);
		chk({8'h00, i_asu_remote_serial.got_byte}, 16'h005A, 16'h00FF);
		chk(16'(i_asu_remote_serial.got_cnt), 16'h0001, 16'hFFFF);
		bus_rd(16'hFFF7, rv);
		bus_wr(16'hFFF5, 16'h2020);
		i_asu_remote_serial.send_char(8'h41, 1'h1);
		rd_chk(16'hFFF6, 16'h5900, 16'hFF00);
		bit_chk(irq, 1'h1);
		// character read at once after the autobaud flag
		rd_chk(16'hFFF4, 16'h0041, 16'h00FF);
		rd_chk(16'hFFF6, 16'h4000, 16'h4100);
		bus_wr(16'hFFF6, 16'h4000);
		wait_cyc(3);
		bit_chk(irq, 1'h0);
		bus_wr(16'hFFF5, 16'h2080);
		i_asu_remote_serial.send_char(8'h31, 1'h1);
		i_asu_remote_serial.send_char(8'h32, 1'h1);
		rd_chk(16'hFFF6, 16'h0300, 16'h0300);
		bit_chk(irq, 1'h1);
		rd_chk(16'hFFF4, 16'h0032, 16'h00FF);
		bus_wr(16'hFFF6, 16'h0200);
		bus_rd(16'hFFF7, rv);
		wait_cyc(3);
		bit_chk(irq, 1'h0);
		i_asu_remote_serial.send_char(8'h55, 1'h0);
		rd_chk(16'hFFF6, 16'h0400, 16'h0600);
		rd_chk(16'hFFF4, 16'h0055, 16'h00FF);
		bus_wr(16'hFFF6, 16'h0400);
		bus_rd(16'hFFF7, rv);
		i_asu_remote_serial.send_char(8'h00, 1'h0);
		wait_cyc(4);
		rd_chk(16'hFFF6, 16'h2000, 16'h2000);
		bit_chk(irq, 1'h1);
		bus_wr(16'hFFF6, 16'h2400);
		rd_chk(16'hFFF6, 16'h0000, 16'h2400);
		// Two stop bits: ready must still be low where one stop bit would have ended
		bus_wr(16'hFFF5, 16'h2040);
		fork
			i_asu_remote_serial.send_char(8'h33, 1'h1);
			begin
				wait_cyc(10400);
				rd_chk(16'hFFF6, 16'h0000, 16'h0100);
			end
		join
		rd_chk(16'hFFF6, 16'h0100, 16'h0500);
		rd_chk(16'hFFF4, 16'h0033, 16'h00FF);
		bus_wr(16'hFFF5, 16'h2200);
		wait_cyc(6);
		bus_wr(16'hFFF6, 16'h00F0);
		ext_pins <= 4'hD;
		wait_cyc(6);
		resetn <= 1'h0;
		wait_cyc(6);
		resetn <= 1'h1;
		rd_chk(16'hFFF6, 16'h1810, 16'hFFF0);
		rd_chk(16'hFFF5, 16'h0000, 16'hFFFF);
		print_verdict();
	end
endmodule : asu_serial_status_tb_top
